// ===== vgo_pkg.sv
// Package: register map, reset values, timing and types for the video gain/offset controller
package vgo_pkg;
  localparam int NCH = 3;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_INPUT_CFG = 10'h005;
  localparam logic [9:0] IDX_OFFSET0 = 10'h009;
  localparam logic [9:0] IDX_OFFSET1 = 10'h00a;
  localparam logic [9:0] IDX_OFFSET2 = 10'h00b;
  localparam logic [9:0] IDX_LOWBITS_RANGE = 10'h00c;
  localparam logic [9:0] IDX_CLAMP_SRC = 10'h013;
  localparam logic [9:0] IDX_START_A = 10'h014;
  localparam logic [9:0] IDX_START_B = 10'h015;
  localparam logic [9:0] IDX_CLAMP_WIDTH = 10'h016;
  localparam logic [9:0] IDX_LOOP_CFG = 10'h017;
  localparam logic [9:0] IDX_GAIN0 = 10'h030;
  localparam logic [9:0] IDX_GAIN1 = 10'h031;
  localparam logic [9:0] IDX_GAIN2 = 10'h032;
  localparam logic [9:0] IDX_STATUS = 10'h038;
  localparam logic [9:0] IDX_DAC0 = 10'h039;
  localparam logic [9:0] IDX_DAC1 = 10'h03a;
  localparam logic [9:0] IDX_DAC2 = 10'h03b;
  // Field positions
  localparam int POS_COAST_CLAMP = 5;
  localparam int POS_RANGE = 0;
  localparam int POS_LOWBITS = 2;
  localparam int POS_SRC_LO = 4;
  localparam int POS_DISABLE = 0;
  localparam int POS_NSAMP = 2;
  localparam int POS_NLINE = 4;
  // Reset values
  localparam logic [7:0] RST_INPUT_CFG = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_LOWBITS_RANGE = 8'h00;
  localparam logic [7:0] RST_CLAMP_SRC = 8'h00;
  localparam logic [7:0] RST_START_A = 8'h00;
  localparam logic [7:0] RST_START_B = 8'h10;
  localparam logic [7:0] RST_CLAMP_WIDTH = 8'h08;
  localparam logic [7:0] RST_LOOP_CFG = 8'h30;
  localparam logic [7:0] RST_GAIN = 8'h55;
  // Converter code that the servo treats as black
  localparam logic [7:0] BLACK_TARGET = 8'h10;
  // Timing
  localparam longint CLK_HZ = 64'd25_000_000;
  localparam longint GAIN_TIMEOUT_MS = 64'd100;
  localparam longint GAIN_TIMEOUT_CYC = GAIN_TIMEOUT_MS * CLK_HZ / 64'd1000;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [NCH-1:0][7:0] chan;
  } vgo_pix_t;

  typedef struct packed {
    logic [NCH-1:0][7:0] gain;
    logic [NCH-1:0][9:0] dac;
    logic range_half;
  } vgo_afe_t;
endpackage

// ===== vgo_ctrl.sv
// Video gain, offset and black-level servo controller with output FIFO
`timescale 1ns/100ps
`default_nettype none

module vgo_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic push, pop;

  assign level = wr_ff - rd_ff;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ff[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_wr = wr_ff + (AW+1)'(push);
    nxt_rd = rd_ff + (AW+1)'(pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
    end
  end

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

module vgo_ctrl #(
  parameter int GAIN_TIMEOUT = int'(vgo_pkg::GAIN_TIMEOUT_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsync_in,
  input wire logic pll_coast_in,
  input wire logic ext_clamp_in,
  input wire logic adc_valid,
  output logic adc_ready,
  input wire vgo_pkg::vgo_pix_t adc_data,
  output logic pix_valid,
  input wire logic pix_ready,
  output vgo_pkg::vgo_pix_t pix_data,
  output vgo_pkg::vgo_afe_t afe_ctrl,
  output logic clamp_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEAS = 2'b01,
    ST_UPDATE = 2'b10
  } vgo_state_t;

  localparam int NCH = vgo_pkg::NCH;

  // ---------------- Register file ----------------
  logic [7:0] cfg_ff, lowr_ff, src_ff, sta_ff, stb_ff, cwid_ff, loop_ff;
  logic [NCH-1:0][7:0] off_ff, gain_ff;
  logic [7:0] nxt_cfg, nxt_lowr, nxt_src, nxt_sta, nxt_stb, nxt_cwid, nxt_loop;
  logic [NCH-1:0][7:0] nxt_off, nxt_gain;
  logic wr_en, rd_hit, gain_wr;
  logic [9:0] idx;
  logic [4:0] fifo_level;
  vgo_state_t st_ff, nxt_st;

  assign idx = paddr[11:2];
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    prdata = 32'h0000_0000;
    unique case (idx)
      vgo_pkg::IDX_INPUT_CFG: prdata[7:0] = cfg_ff;
      vgo_pkg::IDX_OFFSET0: prdata[7:0] = off_ff[0];
      vgo_pkg::IDX_OFFSET1: prdata[7:0] = off_ff[1];
      vgo_pkg::IDX_OFFSET2: prdata[7:0] = off_ff[2];
      vgo_pkg::IDX_LOWBITS_RANGE: prdata[7:0] = lowr_ff;
      vgo_pkg::IDX_CLAMP_SRC: prdata[7:0] = src_ff;
      vgo_pkg::IDX_START_A: prdata[7:0] = sta_ff;
      vgo_pkg::IDX_START_B: prdata[7:0] = stb_ff;
      vgo_pkg::IDX_CLAMP_WIDTH: prdata[7:0] = cwid_ff;
      vgo_pkg::IDX_LOOP_CFG: prdata[7:0] = loop_ff;
      vgo_pkg::IDX_GAIN0: prdata[7:0] = gain_ff[0];
      vgo_pkg::IDX_GAIN1: prdata[7:0] = gain_ff[1];
      vgo_pkg::IDX_GAIN2: prdata[7:0] = gain_ff[2];
      vgo_pkg::IDX_STATUS: prdata[7:0] = {1'b0, st_ff, fifo_level};
      vgo_pkg::IDX_DAC0: prdata[9:0] = afe_ctrl.dac[0];
      vgo_pkg::IDX_DAC1: prdata[9:0] = afe_ctrl.dac[1];
      vgo_pkg::IDX_DAC2: prdata[9:0] = afe_ctrl.dac[2];
      default: rd_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !rd_hit;

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_off = off_ff;
    nxt_lowr = lowr_ff;
    nxt_src = src_ff;
    nxt_sta = sta_ff;
    nxt_stb = stb_ff;
    nxt_cwid = cwid_ff;
    nxt_loop = loop_ff;
    nxt_gain = gain_ff;
    gain_wr = 1'b0;
    if (wr_en) begin
      unique case (idx)
        vgo_pkg::IDX_INPUT_CFG: nxt_cfg = pwdata[7:0];
        vgo_pkg::IDX_OFFSET0: nxt_off[0] = pwdata[7:0];
        vgo_pkg::IDX_OFFSET1: nxt_off[1] = pwdata[7:0];
        vgo_pkg::IDX_OFFSET2: nxt_off[2] = pwdata[7:0];
        vgo_pkg::IDX_LOWBITS_RANGE: nxt_lowr = pwdata[7:0];
        vgo_pkg::IDX_CLAMP_SRC: nxt_src = pwdata[7:0];
        vgo_pkg::IDX_START_A: nxt_sta = pwdata[7:0];
        vgo_pkg::IDX_START_B: nxt_stb = pwdata[7:0];
        vgo_pkg::IDX_CLAMP_WIDTH: nxt_cwid = pwdata[7:0];
        vgo_pkg::IDX_LOOP_CFG: nxt_loop = pwdata[7:0];
        vgo_pkg::IDX_GAIN0: begin
          nxt_gain[0] = pwdata[7:0];
          gain_wr = 1'b1;
        end
        vgo_pkg::IDX_GAIN1: begin
          nxt_gain[1] = pwdata[7:0];
          gain_wr = 1'b1;
        end
        vgo_pkg::IDX_GAIN2: begin
          nxt_gain[2] = pwdata[7:0];
          gain_wr = 1'b1;
        end
        default: gain_wr = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= vgo_pkg::RST_INPUT_CFG;
      off_ff <= {NCH{vgo_pkg::RST_OFFSET}};
      lowr_ff <= vgo_pkg::RST_LOWBITS_RANGE;
      src_ff <= vgo_pkg::RST_CLAMP_SRC;
      sta_ff <= vgo_pkg::RST_START_A;
      stb_ff <= vgo_pkg::RST_START_B;
      cwid_ff <= vgo_pkg::RST_CLAMP_WIDTH;
      loop_ff <= vgo_pkg::RST_LOOP_CFG;
      gain_ff <= {NCH{vgo_pkg::RST_GAIN}};
    end else begin
      cfg_ff <= nxt_cfg;
      off_ff <= nxt_off;
      lowr_ff <= nxt_lowr;
      src_ff <= nxt_src;
      sta_ff <= nxt_sta;
      stb_ff <= nxt_stb;
      cwid_ff <= nxt_cwid;
      loop_ff <= nxt_loop;
      gain_ff <= nxt_gain;
    end
  end

  logic servo_off, range_half, coast_clamp, ext_src;
  logic [15:0] start_pix;
  logic [2:0] nshift;
  logic [2:0] lshift;
  assign servo_off = loop_ff[vgo_pkg::POS_DISABLE];
  assign range_half = lowr_ff[vgo_pkg::POS_RANGE];
  assign coast_clamp = cfg_ff[vgo_pkg::POS_COAST_CLAMP];
  assign ext_src = |src_ff[vgo_pkg::POS_SRC_LO +: 2];
  assign start_pix = {sta_ff, stb_ff};
  // Sample count 4, 8, 16 or 32 pixels
  assign nshift = 3'(loop_ff[vgo_pkg::POS_NSAMP +: 2]) + 3'd2;
  assign lshift = loop_ff[vgo_pkg::POS_NLINE +: 3];

  // ---------------- Pin synchronisers and line timing ----------------
  logic [2:0] hs_sy_ff, co_sy_ff, ec_sy_ff;
  logic hs_ff, co_ff, ec_ff, ec_d_ff, line_coast_ff, clamp_ff;
  logic nxt_hs, nxt_co, nxt_ec, nxt_line_coast, nxt_clamp;
  logic [15:0] pix_cnt_ff, nxt_pix_cnt;
  logic hs_trail, pix_take, coasting;

  assign pix_take = adc_valid && adc_ready;

  always_comb begin
    // A change counts once the second and third stages agree
    nxt_hs = (hs_sy_ff[1] == hs_sy_ff[2]) ? hs_sy_ff[2] : hs_ff;
    nxt_co = (co_sy_ff[1] == co_sy_ff[2]) ? co_sy_ff[2] : co_ff;
    nxt_ec = (ec_sy_ff[1] == ec_sy_ff[2]) ? ec_sy_ff[2] : ec_ff;
    hs_trail = hs_ff && !nxt_hs;
    nxt_pix_cnt = pix_cnt_ff;
    if (hs_trail) begin
      nxt_pix_cnt = 16'h0000;
    end else if (pix_take && pix_cnt_ff != 16'hffff) begin
      nxt_pix_cnt = pix_cnt_ff + 16'h0001;
    end
    nxt_line_coast = hs_trail ? co_ff : (line_coast_ff || co_ff);
    nxt_clamp = (pix_cnt_ff >= start_pix)
      && ({1'b0, pix_cnt_ff} < {1'b0, start_pix} + 17'(cwid_ff));
  end

  assign coasting = !coast_clamp && (line_coast_ff || co_ff);
  assign clamp_out = ext_src ? ec_ff : clamp_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_sy_ff <= 3'h0;
      co_sy_ff <= 3'h0;
      ec_sy_ff <= 3'h0;
      hs_ff <= 1'b0;
      co_ff <= 1'b0;
      ec_ff <= 1'b0;
      ec_d_ff <= 1'b0;
      line_coast_ff <= 1'b0;
      clamp_ff <= 1'b0;
      pix_cnt_ff <= 16'hffff;
    end else begin
      hs_sy_ff <= {hs_sy_ff[1:0], hsync_in};
      co_sy_ff <= {co_sy_ff[1:0], pll_coast_in};
      ec_sy_ff <= {ec_sy_ff[1:0], ext_clamp_in};
      hs_ff <= nxt_hs;
      co_ff <= nxt_co;
      ec_ff <= nxt_ec;
      ec_d_ff <= clamp_out;
      line_coast_ff <= nxt_line_coast;
      clamp_ff <= nxt_clamp;
      pix_cnt_ff <= nxt_pix_cnt;
    end
  end

  // ---------------- Gain loading ----------------
  logic pend_ff, nxt_pend, gain_load;
  logic [31:0] tmo_ff, nxt_tmo;
  logic [NCH-1:0][7:0] gapp_ff, nxt_gapp;

  always_comb begin
    gain_load = clamp_out && !ec_d_ff;
    // forced load when no clamp arrives in time
    if (pend_ff && tmo_ff >= 32'(GAIN_TIMEOUT - 1)) begin
      gain_load = 1'b1;
    end
    nxt_gapp = gain_load ? gain_ff : gapp_ff;
    nxt_pend = gain_wr || (pend_ff && !gain_load);
    nxt_tmo = (gain_load || !pend_ff) ? 32'h0000_0000 : tmo_ff + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
      tmo_ff <= 32'h0000_0000;
      gapp_ff <= {NCH{vgo_pkg::RST_GAIN}};
    end else begin
      pend_ff <= nxt_pend;
      tmo_ff <= nxt_tmo;
      gapp_ff <= nxt_gapp;
    end
  end

  // ---------------- Black-level servo ----------------
  logic [NCH-1:0][12:0] msum_ff, nxt_msum;
  logic [NCH-1:0][15:0] lacc_ff, nxt_lacc;
  logic [NCH-1:0][9:0] dac_ff, nxt_dac;
  logic [5:0] scnt_ff, nxt_scnt;
  logic [7:0] lcnt_ff, nxt_lcnt;
  logic [7:0] avg;
  logic signed [8:0] err;
  logic signed [15:0] mean;
  logic signed [19:0] corr;

  always_comb begin
    nxt_st = st_ff;
    nxt_msum = msum_ff;
    nxt_lacc = lacc_ff;
    nxt_dac = dac_ff;
    nxt_scnt = scnt_ff;
    nxt_lcnt = lcnt_ff;
    avg = 8'h00;
    err = 9'sh000;
    mean = 16'sh0000;
    corr = 20'sh00000;
    unique case (st_ff)
      ST_IDLE: begin
        // start sampling at the start pixel of each line unless the PLL is coasting
        if (!servo_off && pix_take && pix_cnt_ff == start_pix && !coasting) begin
          nxt_st = ST_MEAS;
          nxt_scnt = 6'h00;
          nxt_msum = '0;
        end
      end
      ST_MEAS: begin
        if (servo_off || hs_trail || coasting) begin
          nxt_st = ST_IDLE;
        end else if (pix_take) begin
          // each channel's samples feed the sum
          for (int c = 0; c < NCH; c++) begin
            nxt_msum[c] = msum_ff[c] + 13'(adc_data.chan[c]);
          end
          nxt_scnt = scnt_ff + 6'h01;
          if (nxt_scnt == 6'(1 << nshift)) begin
            nxt_st = ST_UPDATE;
          end
        end
      end
      ST_UPDATE: begin
        nxt_st = ST_IDLE;
        nxt_lcnt = lcnt_ff + 8'h01;
        for (int c = 0; c < NCH; c++) begin
          avg = 8'(msum_ff[c] >> nshift);
          err = $signed({1'b0, avg}) - $signed({1'b0, vgo_pkg::BLACK_TARGET});
          nxt_lacc[c] = lacc_ff[c] + 16'(err);
          // after the selected line count, update the DAC
          if (nxt_lcnt == 8'(1 << lshift)) begin
            mean = $signed(nxt_lacc[c]) >>> lshift;
            // four DAC codes per unit of mean error, eight in half range
            corr = range_half ? 20'(mean) <<< 3 : 20'(mean) <<< 2;
            corr = 20'($signed(dac_ff[c])) - corr;
            if (corr > 20'sd511) begin
              nxt_dac[c] = 10'h1ff;
            end else if (corr < -20'sd512) begin
              nxt_dac[c] = 10'h200;
            end else begin
              nxt_dac[c] = corr[9:0];
            end
            nxt_lacc[c] = 16'h0000;
          end
        end
        if (nxt_lcnt == 8'(1 << lshift)) begin
          nxt_lcnt = 8'h00;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    // line accumulators, line count and DAC held clear while disabled
    if (servo_off) begin
      nxt_lacc = '0;
      nxt_lcnt = 8'h00;
      nxt_dac = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      msum_ff <= '0;
      lacc_ff <= '0;
      dac_ff <= '0;
      scnt_ff <= 6'h00;
      lcnt_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      msum_ff <= nxt_msum;
      lacc_ff <= nxt_lacc;
      dac_ff <= nxt_dac;
      scnt_ff <= nxt_scnt;
      lcnt_ff <= nxt_lcnt;
    end
  end

  // ---------------- Analog front-end controls ----------------
  vgo_pkg::vgo_afe_t afe_ff, nxt_afe;

  always_comb begin
    // gain code passed unchanged; 85 is unity
    nxt_afe.gain = gapp_ff;
    nxt_afe.range_half = range_half;
    for (int c = 0; c < NCH; c++) begin
      // manual DAC from offset and low bits when servo is off
      nxt_afe.dac[c] = servo_off ? {off_ff[c], lowr_ff[vgo_pkg::POS_LOWBITS + 2*c +: 2]}
                                 : dac_ff[c];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afe_ff <= '0;
    end else begin
      afe_ff <= nxt_afe;
    end
  end

  assign afe_ctrl = afe_ff;

  // ---------------- Pixel path ----------------
  vgo_pkg::vgo_pix_t adj;
  logic signed [9:0] sum;

  always_comb begin
    sum = 10'sh000;
    for (int c = 0; c < NCH; c++) begin
      // digital offset only while the servo runs
      sum = $signed({2'b00, adc_data.chan[c]})
        + (servo_off ? 10'sh000 : 10'($signed(off_ff[c])));
      if (sum < 10'sh000) begin
        adj.chan[c] = 8'h00;
      end else if (sum > 10'sh0ff) begin
        adj.chan[c] = 8'hff;
      end else begin
        adj.chan[c] = sum[7:0];
      end
    end
  end

  vgo_fifo #(
    .WIDTH($bits(vgo_pkg::vgo_pix_t)),
    .DEPTH(vgo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(adc_valid),
    .in_ready(adc_ready),
    .in_data(adj),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_data),
    .level(fifo_level)
  );
endmodule

`default_nettype wire

// ===== vgo_ctrl_properties.sv
// Checker: port-level properties of the gain and offset controller
`timescale 1ns/100ps
`default_nettype none
module vgo_ctrl_properties #(
  parameter int GAIN_TIMEOUT = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic adc_valid,
  input wire logic adc_ready,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire vgo_pkg::vgo_afe_t afe_ctrl,
  input wire logic clamp_out
);
  // Shadow of written registers; ages since gain write, clamp rise and any write
  logic [7:0] sh_ff [64];
  logic [7:0] nxt_sh [64];
  int gw_ff, nxt_gw, ca_ff, nxt_ca, occ_ff, nxt_occ, qt_ff, nxt_qt;
  logic cl_ff;
  logic [1:0] up_ff;
  logic wr;
  assign wr = psel && penable && pwrite && pready && paddr[11:8] == 4'h0;
  always_comb begin
    nxt_sh = sh_ff;
    if (wr) begin
      nxt_sh[paddr[7:2]] = pwdata[7:0];
    end
    nxt_gw = (wr && paddr[7:4] == 4'hc) ? 0 : gw_ff + int'(gw_ff < GAIN_TIMEOUT + 8);
    nxt_ca = (clamp_out && !cl_ff) ? 0 : ca_ff + int'(ca_ff < 8);
    nxt_occ = occ_ff + int'(adc_valid && adc_ready) - int'(pix_valid && pix_ready);
    nxt_qt = wr ? 0 : qt_ff + int'(qt_ff < 8);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      foreach (sh_ff[i]) begin
        sh_ff[i] <= (i inside {[48:50]}) ? vgo_pkg::RST_GAIN :
                    ((i == 23) ? vgo_pkg::RST_LOOP_CFG : 8'h00);
      end
      gw_ff <= GAIN_TIMEOUT + 8;
      ca_ff <= 8;
      occ_ff <= 0;
      qt_ff <= 8;
      cl_ff <= 1'b0;
      up_ff <= 2'h0;
    end else begin
      sh_ff <= nxt_sh;
      gw_ff <= nxt_gw;
      ca_ff <= nxt_ca;
      occ_ff <= nxt_occ;
      qt_ff <= nxt_qt;
      cl_ff <= clamp_out;
      up_ff <= up_ff + 2'(up_ff != 2'h3);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_after_reset;
    $rose(presetn);
  endsequence
  sequence s_gain_moved;
    up_ff == 2'h3 ##0 !$stable(afe_ctrl.gain);
  endsequence
  property p_gain_unity;
    s_after_reset |-> ##[1:2] afe_ctrl.gain == {3{vgo_pkg::RST_GAIN}};
  endproperty
  property p_gain_cause;
    s_gain_moved |-> ca_ff <= 4 || gw_ff >= GAIN_TIMEOUT;
  endproperty
  property p_gain_timeout;
    gw_ff == GAIN_TIMEOUT + 6 |-> afe_ctrl.gain == {sh_ff[50], sh_ff[49], sh_ff[48]};
  endproperty
  property p_manual_dac;
    qt_ff == 8 && sh_ff[23][0] |-> afe_ctrl.dac ==
      {sh_ff[11], sh_ff[12][7:6], sh_ff[10], sh_ff[12][5:4], sh_ff[9], sh_ff[12][3:2]};
  endproperty
  property p_range;
    qt_ff == 8 |-> afe_ctrl.range_half == sh_ff[12][0];
  endproperty
  property p_fifo_full;
    adc_ready == (occ_ff < vgo_pkg::FIFO_DEPTH);
  endproperty
  property p_fifo_empty;
    pix_valid == (occ_ff > 0);
  endproperty
  property p_dac_zero;
    s_after_reset |-> (afe_ctrl.dac == '0) [*3];
  endproperty
  a_gain_unity: assert property (p_gain_unity)
    else $error("gain not unity after reset");
  a_gain_cause: assert property (p_gain_cause)
    else $error("gain moved without clamp or timeout");
  a_gain_timeout: assert property (p_gain_timeout)
    else $error("gain write not applied in time");
  a_manual_dac: assert property (p_manual_dac)
    else $error("manual dac value wrong");
  a_range: assert property (p_range)
    else $error("range flag wrong");
  a_fifo_full: assert property (p_fifo_full)
    else $error("input ready disagrees with fill");
  a_fifo_empty: assert property (p_fifo_empty)
    else $error("output valid disagrees with fill");
  a_dac_zero: assert property (p_dac_zero)
    else $error("dac not zero after reset");
endmodule
bind vgo_ctrl vgo_ctrl_properties #(
  .GAIN_TIMEOUT(GAIN_TIMEOUT)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .adc_valid(adc_valid), .adc_ready(adc_ready), .pix_valid(pix_valid),
  .pix_ready(pix_ready), .afe_ctrl(afe_ctrl), .clamp_out(clamp_out)
);
`default_nettype wire

// ===== vgo_video_src.sv
// Partner: video source giving sync, coast flag and a flat-level pixel stream
`timescale 1ns/100ps
`default_nettype none
module vgo_video_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic coast,
  input wire logic [7:0] lvl,
  input wire logic adc_ready,
  output logic hsync_in,
  output logic pll_coast_in,
  output logic adc_valid,
  output vgo_pkg::vgo_pix_t adc_data
);
  // Line of 128 cycles: sync in the first 8, pixels offered from cycle 12
  logic [6:0] pos_ff;
  logic nxt_valid;
  always_comb begin
    nxt_valid = run && pos_ff >= 7'h0c;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= 7'h00;
      hsync_in <= 1'b0;
      pll_coast_in <= 1'b0;
      adc_valid <= 1'b0;
      adc_data <= '0;
    end else begin
      pos_ff <= pos_ff + 7'h01;
      hsync_in <= run && pos_ff < 7'h08;
      pll_coast_in <= coast;
      // Held pixel waits until taken; idle data keeps changing
      if (!adc_valid || adc_ready) begin
        adc_valid <= nxt_valid;
        adc_data <= nxt_valid ? {3{lvl}} : {3{~lvl ^ {1'b0, pos_ff}}};
      end
    end
  end
endmodule
`default_nettype wire

// ===== vgo_ctrl_tb.sv
// Testbench: register, gain, offset, servo and buffer scenarios
`timescale 1ns/100ps
`default_nettype none
module video_gain_offset_black_level_ctrl_tb;
  localparam int GT = 400;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic run = 1'b0;
  logic coast = 1'b0;
  logic ext_clamp = 1'b0;
  logic pix_ready = 1'b1;
  logic [7:0] lvl = 8'h10;
  logic [31:0] prdata, rv;
  logic pready, pslverr, re, hsync, pcoast, adc_valid, adc_ready, pix_valid, clamp_out;
  vgo_pkg::vgo_pix_t adc_data, pix_data;
  vgo_pkg::vgo_afe_t afe;
  logic [9:0] d1, d2;
  int err_total = 0;
  int compares = 0;
  logic [9:0] ri [9] = '{10'h005, 10'h009, 10'h00a, 10'h00b, 10'h00c, 10'h013,
                         10'h014, 10'h015, 10'h017};
  logic [7:0] rx [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h30};
  logic [9:0] wi [5] = '{10'h009, 10'h00a, 10'h00b, 10'h00c, 10'h017};
  logic [7:0] wv [5] = '{8'h12, 8'h80, 8'h7f, 8'h9d, 8'h01};
  always #20 pclk = ~pclk;
  vgo_ctrl #(
    .GAIN_TIMEOUT(GT)
  ) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_in(hsync), .pll_coast_in(pcoast), .ext_clamp_in(ext_clamp),
    .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data(adc_data),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
    .afe_ctrl(afe), .clamp_out(clamp_out)
  );
  vgo_video_src u_src (
    .pclk(pclk), .presetn(presetn), .run(run), .coast(coast), .lvl(lvl),
    .adc_ready(adc_ready), .hsync_in(hsync), .pll_coast_in(pcoast),
    .adc_valid(adc_valid), .adc_data(adc_data)
  );
  task automatic summarize;
    $display("checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A used-up wait counts as a mismatch and ends the run
  task automatic expire(input logic hit);
    if (hit) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    expire(pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d);
    apb(1'b1, ix, d);
  endtask
  task automatic rd(input logic [9:0] ix);
    apb(1'b0, ix, 8'h00);
  endtask
  task automatic wait_dac(output logic [9:0] v);
    int n;
    logic [9:0] old;
    n = 0;
    old = afe.dac[0];
    while (afe.dac[0] === old && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    expire(n == 1000);
    v = afe.dac[0];
  endtask
  initial begin
    int n;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ri[i]) begin
      rd(ri[i]);
      chk("reset value", rv, {24'h0, rx[i]});
    end
    rd(10'h03f);
    chk("unmapped", {rv[30:0], re}, 32'h1);
    chk("gain1 unity", 32'(afe.gain[1]), 32'h55);
    // No sync: only the timeout can load the gain
    wr(vgo_pkg::IDX_GAIN0, 8'h80);
    repeat (GT + 10) @(posedge pclk);
    chk("gain0 no sync", 32'(afe.gain[0]), 32'h80);
    run <= 1'b1;
    repeat (300) @(posedge pclk);
    wr(vgo_pkg::IDX_GAIN1, 8'h20);
    repeat (140) @(posedge pclk);
    chk("gain1 by clamp", 32'(afe.gain[1]), 32'h20);
    // Clamp pulse: find a low, then a rise, then count the high cycles
    n = 0;
    while (clamp_out !== 1'b0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    while (clamp_out !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    expire(n == 300);
    n = 0;
    while (clamp_out === 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("clamp width", n, 32'(vgo_pkg::RST_CLAMP_WIDTH));
    // External clamp selected but absent: gain waits for the timeout
    wr(vgo_pkg::IDX_CLAMP_SRC, 8'h10);
    wr(vgo_pkg::IDX_GAIN2, 8'h33);
    repeat (140) @(posedge pclk);
    chk("gain2 held", 32'(afe.gain[2]), 32'h55);
    repeat (GT) @(posedge pclk);
    chk("gain2 by timeout", 32'(afe.gain[2]), 32'h33);
    ext_clamp <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("ext clamp", 32'(clamp_out), 32'h1);
    ext_clamp <= 1'b0;
    wr(vgo_pkg::IDX_CLAMP_SRC, 8'h00);
    foreach (wi[i]) wr(wi[i], wv[i]);
    repeat (10) @(posedge pclk);
    chk("manual dac", 32'(afe.dac), {2'b00, 10'h1fe, 10'h201, 10'h04b});
    chk("half range", 32'(afe.range_half), 32'h1);
    rd(vgo_pkg::IDX_DAC0);
    chk("dac0 readback", rv, 32'h04b);
    foreach (wi[i]) begin
      rd(wi[i]);
      chk("readback", rv, {24'h0, wv[i]});
    end
    // Servo back on from zero, first with the PLL coasting
    coast <= 1'b1;
    lvl <= 8'h14;
    for (int i = 9; i < 13; i++) wr(10'(i), 8'h00);
    wr(10'h017, 8'h00);
    repeat (400) @(posedge pclk);
    chk("coasting dac", 32'(afe.dac[0]), 32'h0);
    // Coast-clamp bit set: coasting lines are measured too
    wr(vgo_pkg::IDX_INPUT_CFG, 8'h20);
    wait_dac(d1);
    chk("first step", 32'(d1), 32'h3f0);
    coast <= 1'b0;
    wr(vgo_pkg::IDX_INPUT_CFG, 8'h00);
    wait_dac(d2);
    chk("next line step", 32'(d2), 32'(d1 - 10'd16));
    wr(10'h00c, 8'h01);
    wait_dac(d1);
    chk("half range step", 32'(d1), 32'(d2 - 10'd32));
    lvl <= 8'h90;
    wr(10'h009, 8'h7f);
    wr(10'h00a, 8'h80);
    wr(10'h00b, 8'h05);
    repeat (60) @(posedge pclk);
    // Look only at cycles that carry a pixel; the sync gap has none
    repeat (4) begin
      n = 0;
      do begin
        @(negedge pclk);
        n++;
      end while (pix_valid !== 1'b1 && n < 200);
      expire(n == 200);
      chk("offset pixel", {7'h0, pix_valid, pix_data}, 32'h019510ff);
    end
    @(posedge pclk);
    pix_ready <= 1'b0;
    repeat (60) @(posedge pclk);
    chk("full refuses", 32'(adc_ready), 32'h0);
    rd(vgo_pkg::IDX_STATUS);
    chk("full level", 32'(rv[4:0]), 32'(vgo_pkg::FIFO_DEPTH));
    run <= 1'b0;
    pix_ready <= 1'b1;
    repeat (60) @(posedge pclk);
    chk("drained", 32'(pix_valid), 32'h0);
    rd(vgo_pkg::IDX_STATUS);
    chk("empty level", 32'(rv[4:0]), 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
